// [verilog/tsense_pins.sv]
// Serial slave front end and open-drain alert output of a temperature monitor
// Operation
// - Data is sampled at each serial clock rise and outgoing bits change only at its falls, or are released at a start or stop.
// - The data line is open drain: the device only pulls it low or releases it.
// - The alert output asserts when the temperature lies outside the programmed limits.
// - The alert output is open drain and only pulled low or released.
// - One configuration bit picks interrupt or comparator behaviour for the alert.
// - The alert is active low after reset and active high once the polarity bit is set.
// - The three address-select inputs form the low three bits of the 7-bit address.
// - An unconnected address-select input reads as zero through its pull-down.
// - The upper four address bits come from a fixed device-type identifier.
// - A matching address byte is acknowledged, a mismatch is not and returns to idle.
`timescale 1ns/100ps
`include "tsense_consts.svh"
module tsense_pins #(
  parameter logic [3:0] DEVICE_TYPE_ID = `DEV_TYPE_DEFAULT
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // Serial bus pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // Address straps
  input  wire logic [2:0] ADDRESS_SELECT_INPUTS,
  // Alert configuration and events
  input  wire logic       ALERT_BEHAVIOUR_SELECT,
  input  wire logic       ALERT_POLARITY_SELECT,
  input  wire logic       TEMP_OUT_OF_LIMIT,
  input  wire logic       ALERT_CLEAR,
  output logic            ALERT_OUT,
  output logic            ALERT_OE,
  // User side
  input  wire logic [7:0] TX_DATA,
  output logic            TX_LOAD,
  output logic            ADDR_HIT,
  output logic            READ_MODE,
  output logic [7:0]      RX_DATA,
  output logic            RX_VALID
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic                   scl_meta_reg;
  logic                   scl_sync_reg;
  logic                   scl_prev_reg;
  logic                   sda_meta_reg;
  logic                   sda_sync_reg;
  logic                   sda_prev_reg;
  logic [2:0]             addr_meta_reg;
  logic [2:0]             addr_sync_reg;
  tsense_pkg::bus_event_s ev;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= SCL_IN;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= SDA_IN;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // Floating straps settle at zero through the pad pull-down
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      addr_meta_reg <= `ADDR_SEL_RESET;
      addr_sync_reg <= `ADDR_SEL_RESET;
    end else begin
      addr_meta_reg <= ADDRESS_SELECT_INPUTS;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  // Start and stop are data edges while the clock stays high
  always_comb begin
    ev.scl_rise = scl_sync_reg & ~scl_prev_reg;
    ev.scl_fall = ~scl_sync_reg & scl_prev_reg;
    ev.start    = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    ev.stop     = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  tsense_pkg::link_state_e state_reg;
  logic [2:0]              cnt_reg;
  logic                    byte_done_reg;
  logic                    nack_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              tx_shift_reg;
  logic [6:0]              own_addr;

  assign own_addr = {DEVICE_TYPE_ID, addr_sync_reg};

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg     <= tsense_pkg::ST_IDLE;
      cnt_reg       <= `BIT_CNT_RESET;
      byte_done_reg <= 1'b0;
      nack_reg      <= 1'b0;
      shift_reg     <= `SHIFT_RESET;
      tx_shift_reg  <= `SHIFT_RESET;
      SDA_OE        <= 1'b0;
      READ_MODE     <= 1'b0;
      RX_DATA       <= `SHIFT_RESET;
      RX_VALID      <= 1'b0;
      ADDR_HIT      <= 1'b0;
      TX_LOAD       <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      ADDR_HIT <= 1'b0;
      TX_LOAD  <= 1'b0;
      if (ev.start) begin
        state_reg     <= tsense_pkg::ST_ADDR;
        cnt_reg       <= `BIT_CNT_RESET;
        byte_done_reg <= 1'b0;
        SDA_OE        <= 1'b0;
      end else if (ev.stop) begin
        state_reg <= tsense_pkg::ST_IDLE;
        SDA_OE    <= 1'b0;
      end else begin
        case (state_reg)
          tsense_pkg::ST_ADDR, tsense_pkg::ST_RX: begin
            if (ev.scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg};
              cnt_reg   <= cnt_reg + 3'h1;
              if (cnt_reg == `BIT_CNT_LAST) begin
                byte_done_reg <= 1'b1;
              end
            end
            if (ev.scl_fall && byte_done_reg) begin
              byte_done_reg <= 1'b0;
              if (state_reg == tsense_pkg::ST_RX) begin
                SDA_OE    <= 1'b1;
                RX_DATA   <= shift_reg;
                RX_VALID  <= 1'b1;
                state_reg <= tsense_pkg::ST_RX_ACK;
              end else if (shift_reg[7:1] == own_addr) begin
                SDA_OE    <= 1'b1;
                READ_MODE <= shift_reg[0];
                ADDR_HIT  <= 1'b1;
                state_reg <= tsense_pkg::ST_ADDR_ACK;
              end else begin
                state_reg <= tsense_pkg::ST_IDLE;
              end
            end
          end
          tsense_pkg::ST_ADDR_ACK, tsense_pkg::ST_RX_ACK: begin
            if (ev.scl_fall) begin
              cnt_reg <= `BIT_CNT_RESET;
              if (READ_MODE) begin
                tx_shift_reg <= TX_DATA;
                SDA_OE       <= ~TX_DATA[7];
                TX_LOAD      <= 1'b1;
                state_reg    <= tsense_pkg::ST_TX;
              end else begin
                SDA_OE    <= 1'b0;
                state_reg <= tsense_pkg::ST_RX;
              end
            end
          end
          tsense_pkg::ST_TX: begin
            if (ev.scl_rise) begin
              cnt_reg <= cnt_reg + 3'h1;
              if (cnt_reg == `BIT_CNT_LAST) begin
                byte_done_reg <= 1'b1;
              end
            end
            if (ev.scl_fall) begin
              if (byte_done_reg) begin
                byte_done_reg <= 1'b0;
                SDA_OE        <= 1'b0;
                state_reg     <= tsense_pkg::ST_TX_ACK;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                SDA_OE       <= ~tx_shift_reg[6];
              end
            end
          end
          tsense_pkg::ST_TX_ACK: begin
            if (ev.scl_rise) begin
              nack_reg <= sda_sync_reg;
            end
            if (ev.scl_fall) begin
              cnt_reg <= `BIT_CNT_RESET;
              if (nack_reg) begin
                state_reg <= tsense_pkg::ST_IDLE;
              end else begin
                tx_shift_reg <= TX_DATA;
                SDA_OE       <= ~TX_DATA[7];
                TX_LOAD      <= 1'b1;
                state_reg    <= tsense_pkg::ST_TX;
              end
            end
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // Both open-drain data levels are a constant low; only the enable moves
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SDA_OUT   <= 1'b0;
      ALERT_OUT <= 1'b0;
    end else begin
      SDA_OUT   <= 1'b0;
      ALERT_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Alert output
  // ----------------------------------------------------------------
  logic cond_prev_reg;
  logic pending_reg;
  logic pending_next;
  logic active_next;

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    pending_next = (TEMP_OUT_OF_LIMIT & ~cond_prev_reg) | (pending_reg & ~ALERT_CLEAR);
    active_next  = ALERT_BEHAVIOUR_SELECT ? pending_next : TEMP_OUT_OF_LIMIT;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cond_prev_reg <= 1'b0;
      pending_reg   <= 1'b0;
      ALERT_OE      <= 1'b0;
    end else begin
      cond_prev_reg <= TEMP_OUT_OF_LIMIT;
      pending_reg   <= pending_next;
      // Active-high on an open drain: release when asserted
      ALERT_OE      <= ALERT_POLARITY_SELECT ? ~active_next : active_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_addr_end;
    state_reg == tsense_pkg::ST_ADDR && ev.scl_fall && byte_done_reg && !ev.start && !ev.stop;
  endsequence

  sequence seq_back_idle;
    state_reg == tsense_pkg::ST_IDLE && !SDA_OE && !ADDR_HIT;
  endsequence

  property p_mismatch_idle;
    @(posedge CLK) disable iff (RESET)
      (seq_addr_end and (shift_reg[7:1] != own_addr)) |=> seq_back_idle;
  endproperty

  chk_sda_open_drain: assert property (@(posedge CLK) disable iff (RESET)
    SDA_OUT == 1'b0) else $error("data pin driven high");
  chk_sda_fall_only: assert property (@(posedge CLK) disable iff (RESET)
    $changed(SDA_OE) |-> $past(ev.scl_fall) || $past(ev.start) || $past(ev.stop))
    else $error("data pin changed outside a clock fall");
  chk_addr_own_match: assert property (@(posedge CLK) disable iff (RESET)
    ADDR_HIT |-> SDA_OE && $past(shift_reg[7:1]) == $past(own_addr))
    else $error("address acknowledged without a match");
  chk_addr_mismatch_idle: assert property (p_mismatch_idle)
    else $error("mismatched address not dropped to idle");
  chk_alert_open_drain: assert property (@(posedge CLK) disable iff (RESET)
    ALERT_OUT == 1'b0) else $error("alert pin driven high");
  chk_comparator_alert: assert property (@(posedge CLK) disable iff (RESET)
    (!ALERT_BEHAVIOUR_SELECT && !ALERT_POLARITY_SELECT && TEMP_OUT_OF_LIMIT) |=> ALERT_OE)
    else $error("comparator alert not asserted");
  chk_interrupt_sticky: assert property (@(posedge CLK) disable iff (RESET)
    (ALERT_BEHAVIOUR_SELECT && !ALERT_POLARITY_SELECT && $rose(TEMP_OUT_OF_LIMIT))
    ##1 (ALERT_BEHAVIOUR_SELECT && !ALERT_POLARITY_SELECT && !ALERT_CLEAR) |=> ALERT_OE)
    else $error("interrupt alert not held");
  chk_alert_low_idle: assert property (@(posedge CLK) disable iff (RESET)
    (!ALERT_BEHAVIOUR_SELECT && !ALERT_POLARITY_SELECT && !TEMP_OUT_OF_LIMIT) |=> !ALERT_OE)
    else $error("active-low alert pulled while inactive");
  chk_alert_high_release: assert property (@(posedge CLK) disable iff (RESET)
    (!ALERT_BEHAVIOUR_SELECT && ALERT_POLARITY_SELECT) |=> ALERT_OE == !$past(TEMP_OUT_OF_LIMIT))
    else $error("active-high alert drive wrong");

endmodule // tsense_pins

// [verilog/tsense_consts.svh]
// Constants for the temperature sensor serial and alert pin logic
`ifndef TSENSE_CONSTS_SVH
`define TSENSE_CONSTS_SVH
// Arbitrary neutral device-type value; the real part uses its own
`define DEV_TYPE_DEFAULT 4'h5
`define ADDR_SEL_RESET   3'h0
`define BIT_CNT_RESET    3'h0
`define BIT_CNT_LAST     3'h7
`define SHIFT_RESET      8'h00
`endif

// [verilog/tsense_pkg.sv]
// Types shared by the temperature sensor serial and alert pin logic
package tsense_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } link_state_e;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_event_s;
endpackage

// [verification/i2c_master_model.sv]
// Behavioural bus master that drives the serial clock and pulls the data wire
`timescale 1ns/100ps
module i2c_master_model (
  // Bus pins
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Quarter of the 160 ns link period
  localparam int Q = 40;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // SDA changes only in the low half; the reply is sampled well into the high half
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic start();
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask

  // Clock is left high afterwards, so the bus stays idle between frames
  task automatic stop();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #(4*Q);
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule // i2c_master_model

// [verification/test_temp_sensor_serial_alert_pins.sv]
// Self-checking bench for the serial slave and alert pin logic
`timescale 1ns/100ps
module test_temp_sensor_serial_alert_pins;
  // Arbitrary device-type value
  localparam logic [3:0] DEV_ID = 4'ha;
  logic CLK = 1'b0, RESET = 1'b1, temp = 1'b0, aclr = 1'b0, mode_sel = 1'b0, pol_sel = 1'b0;
  logic [2:0] addr_sel = 3'h0;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic scl, sda_pull, sda, sda_out, sda_oe, alert_out, alert_oe, tx_load, addr_hit;
  logic read_mode, rx_valid, oe_mid = 1'b0;
  int num_errors = 0, cmp_count = 0, cyc = 0, rx_cnt = 0, hit_cnt = 0, load_cnt = 0;

  initial begin
    forever #10 CLK = !CLK;
  end

  // Pull-up wire; a device level other than low would show through while enabled
  assign sda = (sda_oe ? sda_out : 1'b1) && !sda_pull;

  i2c_master_model m (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  tsense_pins #(.DEVICE_TYPE_ID(DEV_ID)) i_dut (
    .CLK(CLK), .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDRESS_SELECT_INPUTS(addr_sel), .ALERT_BEHAVIOUR_SELECT(mode_sel),
    .ALERT_POLARITY_SELECT(pol_sel), .TEMP_OUT_OF_LIMIT(temp), .ALERT_CLEAR(aclr),
    .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .TX_DATA(tx_data), .TX_LOAD(tx_load),
    .ADDR_HIT(addr_hit), .READ_MODE(read_mode), .RX_DATA(rx_data), .RX_VALID(rx_valid));

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t bit got %b exp %b", $time, g, e);
    end
  endtask

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic exp_oe(input logic active, input logic alert_polarity_select);
    return alert_polarity_select ? !active : active;
  endfunction

  always @(posedge CLK) begin
    cyc++;
    rx_cnt   += int'(rx_valid === 1'b1);
    hit_cnt  += int'(addr_hit === 1'b1);
    load_cnt += int'(tx_load === 1'b1);
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // Device output may only move while the clock is low
  always @(posedge scl) #60 oe_mid = sda_oe;
  always @(negedge scl) check_bit(sda_oe, oe_mid);

  initial begin
    logic ack, pend, tprev;
    logic [7:0] d;
    logic [2:0] sel;
    int h;
    void'($urandom(77));
    repeat (6) @(posedge CLK);
    #1 RESET = 1'b0;
    check_bit(sda_oe, 1'b0);
    check_bit(alert_oe, 1'b0);
    for (int k = 0; k < 6; k++) begin
      // First pass stands for floating straps, which read as zero
      sel = (k == 0) ? 3'h0 : 3'($urandom);
      addr_sel = sel;
      d = 8'($urandom);
      tx_data = 8'($urandom);
      h = hit_cnt;
      #300;
      m.start();
      m.write_byte({DEV_ID, sel, 1'b0}, ack);
      check_bit(ack, 1'b1);
      check_bit(read_mode, 1'b0);
      m.write_byte(d, ack);
      check_bit(ack, 1'b1);
      m.stop();
      check_byte(rx_data, d);
      check_bit(1'(rx_cnt == k + 1), 1'b1);
      m.start();
      m.write_byte({DEV_ID, sel, 1'b1}, ack);
      check_bit(ack, 1'b1);
      check_bit(read_mode, 1'b1);
      m.read_byte(1'b1, d);
      check_byte(d, tx_data);
      check_bit(sda_out, 1'b0);
      m.read_byte(1'b0, d);
      m.stop();
      check_byte(d, tx_data);
      check_bit(1'(load_cnt == 2 * (k + 1) && hit_cnt == h + 2), 1'b1);
      m.start();
      m.write_byte({DEV_ID, sel ^ (3'h1 << (k % 3)), 1'b0}, ack);
      check_bit(ack, 1'b0);
      m.write_byte(d, ack);
      check_bit(ack, 1'b0);
      m.start();
      m.write_byte({DEV_ID ^ 4'(1 << (k % 4)), sel, 1'b1}, ack);
      check_bit(ack, 1'b0);
      m.stop();
    end
    // Each mode and polarity; every pass also checks the alert level stays low
    for (int p = 0; p < 4; p++) begin
      mode_sel = p[0];
      pol_sel = p[1];
      temp = 1'b0;
      aclr = 1'b1;
      @(posedge CLK);
      #1 aclr = 1'b0;
      @(posedge CLK);
      #1 pend = 1'b0;
      tprev = 1'b0;
      repeat (40) begin
        temp = 1'($urandom);
        aclr = ($urandom % 6) == 0;
        pend = (temp && !tprev) ? 1'b1 : (aclr ? 1'b0 : pend);
        tprev = temp;
        @(posedge CLK);
        #1;
        check_bit(alert_oe, exp_oe(mode_sel ? pend : temp, pol_sel));
        check_bit(alert_out, 1'b0);
      end
    end
    // Host answers a raised alert by querying over the bus; the alert stands meanwhile
    mode_sel = 1'b0;
    pol_sel = 1'b0;
    temp = 1'b1;
    m.start();
    m.write_byte({DEV_ID, sel, 1'b1}, ack);
    check_bit(ack, 1'b1);
    m.read_byte(1'b0, d);
    m.stop();
    check_byte(d, tx_data);
    check_bit(alert_oe, 1'b1);
    finish_test();
  end
endmodule // test_temp_sensor_serial_alert_pins
